//--- tbpd_port.sv
// Two-pin general-purpose port with direction control behind APB
//
// Behaviour
// - Direction one enables driver, zero tristates
// - Reset clears both direction bits
// - Direction bits read back last written
// - Output pin reads back its latch
// - Input pin reads back synchronised level
// - Data writes always update latches
// - One latch and direction bit per pin
module tbpd_port
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire tbpd_pkg::tbpd_apb_req_t apb_req,
    output tbpd_pkg::tbpd_apb_rsp_t apb_rsp,
    // Pins
    input wire logic [1:0] pin_in,
    output tbpd_pkg::tbpd_pins_t pins
);
    import tbpd_pkg::*;

    tbpd_state_t state;
    tbpd_state_t next_state;
    logic access;

    // Access phase of a transfer; always answered one cycle after it starts
    assign access = apb_req.psel & apb_req.penable;

    // Next state of the whole port
    always_comb
    begin
        next_state = state;
        // Pin levels come from outside, so two flops before use
        next_state.pin_sync1 = pin_in;
        next_state.pin_sync2 = state.pin_sync1;
        next_state.rsp.pready = access & ~state.rsp.pready;
        next_state.rsp.pslverr = 1'b0;
        next_state.rsp.prdata = READ_ZERO;
        if (access & ~state.rsp.pready)
        begin
            if (apb_req.pwrite)
            begin
                if (apb_req.paddr == DATA_ADDR)
                begin
                    // Latch stores even for input pins
                    next_state.pin_output_latch = apb_req.pwdata[1:0];
                end
                else if (apb_req.paddr == DIR_ADDR)
                begin
                    next_state.pin_direction_bits = apb_req.pwdata[1:0];
                end
                else
                begin
                    next_state.rsp.pslverr = 1'b1;
                end
            end
            else
            begin
                if (apb_req.paddr == DATA_ADDR)
                begin
                    // Per pin: latch when output, pin when input
                    next_state.rsp.prdata[1:0] =
                        (state.pin_direction_bits & state.pin_output_latch) |
                        (~state.pin_direction_bits & state.pin_sync2);
                end
                else if (apb_req.paddr == DIR_ADDR)
                begin
                    next_state.rsp.prdata[1:0] = state.pin_direction_bits;
                end
                else
                begin
                    next_state.rsp.pslverr = 1'b1;
                end
            end
        end
        // Drivers follow the registered state, so a latch written before
        // the direction change avoids a glitch on the pin
        next_state.pins.pin_out = next_state.pin_output_latch;
        next_state.pins.pin_oe_n = ~next_state.pin_direction_bits;
    end

    // Register the state; latch reset value is a defined zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state.pin_direction_bits <= DIR_RESET;
            state.pin_output_latch <= LATCH_RESET;
            state.pin_sync1 <= 2'h0;
            state.pin_sync2 <= 2'h0;
            state.rsp <= '0;
            state.pins.pin_out <= LATCH_RESET;
            state.pins.pin_oe_n <= 2'h3;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign apb_rsp = state.rsp;
    assign pins = state.pins;
endmodule : tbpd_port

//--- tbpd_pkg.sv
// Package with register map, field layout and carrier types of the port
package tbpd_pkg;
    localparam int PIN_COUNT = 2;
    // Word indices: data index as printed, direction index chosen
    localparam logic [11:0] DATA_IDX = 12'h000b;
    localparam logic [11:0] DIR_IDX = 12'h000f;
    // Byte addresses on APB are four times the index (one word each)
    localparam logic [11:0] DATA_ADDR = {DATA_IDX[9:0], 2'b00};
    localparam logic [11:0] DIR_ADDR = {DIR_IDX[9:0], 2'b00};
    localparam logic [1:0] DIR_RESET = 2'h0;
    localparam logic [1:0] LATCH_RESET = 2'h0;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } tbpd_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tbpd_apb_rsp_t;

    // Pin side signals
    typedef struct packed {
        logic [1:0] pin_out;
        logic [1:0] pin_oe_n;
    } tbpd_pins_t;

    // All state of the port
    typedef struct packed {
        logic [1:0] pin_direction_bits;
        logic [1:0] pin_output_latch;
        logic [1:0] pin_sync1;
        logic [1:0] pin_sync2;
        tbpd_apb_rsp_t rsp;
        tbpd_pins_t pins;
    } tbpd_state_t;
endpackage : tbpd_pkg

//--- tbpd_port_props.sv
// Checker of bus answers and pin behaviour of the two-pin port
module tbpd_port_props
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Watched ports
    input wire tbpd_pkg::tbpd_apb_req_t apb_req,
    input wire tbpd_pkg::tbpd_apb_rsp_t apb_rsp,
    input wire logic [1:0] pin_in,
    input wire tbpd_pkg::tbpd_pins_t pins
);
    import tbpd_pkg::*;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Short names; oe is one where the pin is driven
    wire logic [1:0] oe = ~pins.pin_oe_n;
    wire logic [1:0] dq = apb_rsp.prdata[1:0];
    wire logic [11:0] ad = apb_req.paddr;
    // First access cycle, and a read answer from a given address
    sequence acc_s;
        apb_req.psel && apb_req.penable && !apb_rsp.pready;
    endsequence
    sequence rd_s(a);
        apb_rsp.pready && !apb_req.pwrite && ad == a;
    endsequence
    AST_DIR_DRV: assert property (acc_s ##0 (apb_req.pwrite && ad == DIR_ADDR)
        |=> oe == $past(apb_req.pwdata[1:0])) else $error("bad enable");
    AST_RST_IN: assert property ($rose(presetn) |-> pins.pin_oe_n == 2'h3)
        else $error("pins not inputs");
    AST_LATCH: assert property (acc_s ##0 (apb_req.pwrite && ad == DATA_ADDR)
        |=> pins.pin_out == $past(apb_req.pwdata[1:0])) else $error("bad latch");
    AST_RD_OUT: assert property (rd_s(DATA_ADDR)
        |-> (dq & oe) == (pins.pin_out & oe)) else $error("bad latch read");
    // Input bits come through two sync stages and the read register
    AST_RD_IN: assert property (rd_s(DATA_ADDR)
        |-> (dq & ~oe) == ($past(pin_in, 3) & ~oe)) else $error("bad pin read");
    AST_RD_DIR: assert property (rd_s(DIR_ADDR) |-> dq == oe)
        else $error("bad direction read");
    AST_WIDTH: assert property (apb_rsp.pready
        |-> apb_rsp.prdata[31:2] == 0 ##1 !apb_rsp.pready) else $error("bad answer");
    AST_UNMAP: assert property (acc_s ##0 (ad != DATA_ADDR && ad != DIR_ADDR)
        |=> apb_rsp.pslverr && apb_rsp.pready) else $error("no error answer");
endmodule : tbpd_port_props

bind tbpd_port tbpd_port_props u_props (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .pin_in(pin_in), .pins(pins));

//--- tbpd_port_tb.sv
// Self-checking bench of the two-pin port
module tbpd_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tbpd_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic [1:0] pin_in = 2'h0;
    logic er;
    logic [31:0] rd;
    int fails = 0;
    int tests_run = 0;
    tbpd_apb_req_t req = '0;
    tbpd_apb_rsp_t rsp;
    tbpd_pins_t pins;
    tbpd_port u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .apb_rsp(rsp), .pin_in(pin_in), .pins(pins));
    // Free-running 10 MHz clock
    initial
    begin
        forever #50 pclk = ~pclk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : chk
    task end_of_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    // One transfer; bounded wait so a dead slave cannot hang the run
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        req <= '{1'h1, 1'h0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'h1;
        n = 0;
        do @(posedge pclk); while (rsp.pready !== 1'h1 && ++n < 20);
        // A slave that never answers counts as a mismatch
        if (rsp.pready !== 1'h1)
            fails++;
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask : apb
    task t_input;
        apb(1'h0, DIR_ADDR, 2'h0);
        chk({rd, pins.pin_oe_n}, 2'h3);
        pin_in <= 2'h2;
        apb(1'h1, DATA_ADDR, 2'h1);
        apb(1'h0, DATA_ADDR, 2'h0);
        chk({rd, pins.pin_oe_n}, 4'hb);
        chk({30'h0, pins.pin_out}, 32'h1);
    endtask : t_input
    // Latch already loaded, so pin 0 starts high without a glitch
    task t_output;
        apb(1'h1, DIR_ADDR, 2'h1);
        apb(1'h0, DIR_ADDR, 2'h0);
        chk({rd, pins.pin_oe_n, pins.pin_out}, 8'h19);
        apb(1'h0, DATA_ADDR, 2'h0);
        chk(rd, 2'h3);
        apb(1'h0, 12'h004, 2'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
    endtask : t_output
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        t_input;
        t_output;
        end_of_test;
    end
    // Watchdog far beyond the few dozen cycles the tests need
    initial
    begin
        #100000;
        fails++;
        end_of_test;
    end
endmodule : tbpd_port_tb
